// ### core/dlc_pkg.sv
// shared constants and carriers for the loop configuration registers
package dlc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] ACQ_BW_ADDR = 7'h69;
  localparam logic [ADDR_W-1:0] AUX_DAMP_ADDR = 7'h6A;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int unsigned BW_LSB = 0;
  localparam int unsigned BW_W = 4;
  localparam int unsigned DAMP_LSB = 0;
  localparam int unsigned DAMP_W = 3;
  localparam int unsigned GAIN_LSB = 4;
  localparam int unsigned GAIN_W = 3;
  localparam logic [DATA_W-1:0] ACQ_BW_MASK = 8'h0F;
  localparam logic [DATA_W-1:0] AUX_DAMP_MASK = 8'h77;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] ACQ_BW_RESET = 8'h00;
  localparam logic [DATA_W-1:0] AUX_DAMP_RESET = 8'h13;
  // gain used when the lowrate gain field is not in force
  localparam logic [GAIN_W-1:0] GAIN_DEFAULT = 3'h1;

  // ----------------------------------------------------------------
  // bandwidth codes, 0.3 Hz up to 18 Hz
  // ----------------------------------------------------------------
  localparam logic [BW_W-1:0] BW_0P3_HZ = 4'h8;
  localparam logic [BW_W-1:0] BW_18_HZ = 4'hE;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dlc_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] acq_bw;
    logic [DATA_W-1:0] aux_damp;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic [BW_W-1:0] main_bw;
    logic [GAIN_W-1:0] aux_gain;
    logic [DAMP_W-1:0] aux_damp_code;
  } dlc_state_t;

endpackage

// ### core/dlc_regs.sv
// loop configuration registers: acquisition bandwidth and aux damping
//
// How it works
// R01: acquisition bandwidth register is read/write; bits 7:4 unused, 3:0 code.
// R02: unlocked main loop applies the acquisition code, 0.3 Hz to 18 Hz.
// R03: aux damping register bits 6:4 set the second detector gain.
// R04: that gain applies only for 8 kHz or lower references, analog feedback.
// R05: gain field ignored unless gain selection enabled by register 6C bit 7.
// R06: aux damping resets to 0x13; bits 7, 3 unused; damping in 2:0.
`timescale 1ns/1ns
`default_nettype none

module dlc_regs
  import dlc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_main_locked,
  input wire logic [BW_W-1:0] i_locked_bandwidth_code,
  input wire logic i_aux_lowrate_analog,
  input wire logic i_gain_select_en,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_rvalid,
  output logic [BW_W-1:0] o_main_bandwidth_code,
  output logic [GAIN_W-1:0] o_aux_detector2_gain,
  output logic [DAMP_W-1:0] o_aux_damping_code
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dlc_req_t req;
  dlc_state_t s_q;
  dlc_state_t s_d;

  assign req = '{wr_en: i_wr_en, rd_en: i_rd_en, addr: i_addr,
                 wdata: i_wdata};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.rdata = '0;
    if (req.wr_en) begin
      case (req.addr)
        ACQ_BW_ADDR: begin
          s_d.acq_bw = req.wdata & ACQ_BW_MASK; // R01
        end
        AUX_DAMP_ADDR: begin
          s_d.aux_damp = req.wdata & AUX_DAMP_MASK; // R06
        end
        default: begin
          s_d.acq_bw = s_q.acq_bw;
        end
      endcase
    end
    if (req.rd_en) begin
      s_d.rvalid = 1'b1;
      case (req.addr)
        ACQ_BW_ADDR: begin
          s_d.rdata = s_q.acq_bw; // R01
        end
        AUX_DAMP_ADDR: begin
          s_d.rdata = s_q.aux_damp;
        end
        default: begin
          s_d.rdata = '0;
        end
      endcase
    end
    // acquisition bandwidth while unlocked, locked bandwidth otherwise
    if (i_main_locked) begin
      s_d.main_bw = i_locked_bandwidth_code;
    end else begin
      s_d.main_bw = s_q.acq_bw[BW_LSB +: BW_W]; // R02
    end
    // lowrate gain only when enabled and the reference qualifies
    if (i_gain_select_en && i_aux_lowrate_analog) begin // R04 R05
      s_d.aux_gain = s_q.aux_damp[GAIN_LSB +: GAIN_W]; // R03
    end else begin
      s_d.aux_gain = GAIN_DEFAULT;
    end
    s_d.aux_damp_code = s_q.aux_damp[DAMP_LSB +: DAMP_W]; // R06
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q.acq_bw <= ACQ_BW_RESET;
      s_q.aux_damp <= AUX_DAMP_RESET; // R06
      s_q.rdata <= '0;
      s_q.rvalid <= 1'b0;
      s_q.main_bw <= ACQ_BW_RESET[BW_LSB +: BW_W];
      s_q.aux_gain <= GAIN_DEFAULT;
      s_q.aux_damp_code <= AUX_DAMP_RESET[DAMP_LSB +: DAMP_W];
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rdata = s_q.rdata;
  assign o_rvalid = s_q.rvalid;
  assign o_main_bandwidth_code = s_q.main_bw;
  assign o_aux_detector2_gain = s_q.aux_gain;
  assign o_aux_damping_code = s_q.aux_damp_code;

endmodule

`default_nettype wire

// ### tb/dlc_regs_monitor.sv
// assertions on the loop configuration register ports
`timescale 1ns/1ns
`default_nettype none
module dlc_regs_monitor
  import dlc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_main_locked,
  input wire logic i_aux_lowrate_analog,
  input wire logic i_gain_select_en,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic [BW_W-1:0] o_main_bandwidth_code,
  input wire logic [GAIN_W-1:0] o_aux_detector2_gain,
  input wire logic [DAMP_W-1:0] o_aux_damping_code
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  sequence acq_wr_s; i_wr_en && i_addr == ACQ_BW_ADDR; endsequence
  sequence aux_wr_s; i_wr_en && i_addr == AUX_DAMP_ADDR; endsequence
  read_answer_a: assert property (
    i_rd_en |=> o_rvalid) else $error("read not answered");
  acq_unused_a: assert property (
    o_rvalid && $past(i_addr) == ACQ_BW_ADDR |-> o_rdata[7:4] == 4'h0)
    else $error("unused bandwidth bits read set");
  acq_apply_a: assert property (
    acq_wr_s ##1 !i_main_locked |=>
    o_main_bandwidth_code == $past(i_wdata[3:0], 2))
    else $error("acquire code not applied");
  gain_field_a: assert property (
    aux_wr_s ##1 (i_gain_select_en && i_aux_lowrate_analog) |=>
    o_aux_detector2_gain == $past(i_wdata[6:4], 2))
    else $error("lowrate gain not applied");
  gain_rate_a: assert property (
    !i_aux_lowrate_analog |=> o_aux_detector2_gain == GAIN_DEFAULT)
    else $error("gain used outside lowrate mode");
  gain_gate_a: assert property (
    !i_gain_select_en |=> o_aux_detector2_gain == GAIN_DEFAULT)
    else $error("gain used while disabled");
  damp_code_a: assert property (
    aux_wr_s ##1 1'b1 |=> o_aux_damping_code == $past(i_wdata[2:0], 2))
    else $error("damping code not applied");
endmodule
bind dlc_regs dlc_regs_monitor i_mon (.*);
`default_nettype wire

// ### tb/dlc_regs_bench.sv
// self-checking bench for the loop configuration registers
`timescale 1ns/1ns
`default_nettype none
`define CHK(n,e,s) begin num_checks++; if ((s) !== (e)) begin errors++; \
  $display("Error %s exp %0h got %0h", n, e, s); end end
module dlc_regs_bench
  import dlc_pkg::*;
;
  logic i_clock = 0, i_arst_n = 0, i_wr_en = 0, i_rd_en = 0, o_rvalid;
  logic i_main_locked = 0, i_aux_lowrate_analog = 0, i_gain_select_en = 0;
  logic [ADDR_W-1:0] i_addr = 7'h00;
  logic [DATA_W-1:0] i_wdata = 8'h00, o_rdata;
  logic [BW_W-1:0] i_locked_bandwidth_code = 4'h0, o_main_bandwidth_code;
  logic [GAIN_W-1:0] o_aux_detector2_gain;
  logic [DAMP_W-1:0] o_aux_damping_code;
  logic [6:0] a;
  logic [7:0] d;
  logic [BW_W-1:0] exp_bw;
  logic [GAIN_W-1:0] exp_gain;
  int errors = 0, num_checks = 0, seed = 91, cyc = 0, acq = 0, damp = 8'h13;
  dlc_regs i_dut (.*);
  always #50 i_clock = ~i_clock;
  task complete_run;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      complete_run;
    end
  end
  task rd(input logic [6:0] ra, input int e);
    @(negedge i_clock) {i_rd_en, i_addr} = {1'b1, ra};
    @(negedge i_clock) i_rd_en = 0;
    `CHK("rvalid", 1'b1, o_rvalid)
    `CHK("rdata", e[7:0], o_rdata)
  endtask
  initial begin
    repeat (8) @(negedge i_clock);
    i_arst_n = 1;
    `CHK("damp", 3'h3, o_aux_damping_code)
    `CHK("gain", 3'h1, o_aux_detector2_gain)
    rd(ACQ_BW_ADDR, 0);
    rd(AUX_DAMP_ADDR, 8'h13);
    $display("test reset done");
    repeat (40) begin
      a = ($random(seed) & 1) ? AUX_DAMP_ADDR : ACQ_BW_ADDR;
      if (!($random(seed) % 5)) a = $random(seed);
      d = $random(seed);
      @(negedge i_clock);
      {i_main_locked, i_aux_lowrate_analog, i_gain_select_en} = $random(seed);
      i_locked_bandwidth_code = $random(seed);
      {i_wr_en, i_addr, i_wdata} = {1'b1, a, d};
      @(negedge i_clock) i_wr_en = 0;
      if (a == ACQ_BW_ADDR) acq = d & 8'h0F;
      if (a == AUX_DAMP_ADDR) damp = d & 8'h77;
      @(negedge i_clock);
      exp_bw = i_main_locked ? i_locked_bandwidth_code : acq[3:0];
      exp_gain = 3'h1;
      if (i_gain_select_en && i_aux_lowrate_analog) exp_gain = damp[6:4];
      `CHK("bw", exp_bw, o_main_bandwidth_code)
      `CHK("gain", exp_gain, o_aux_detector2_gain)
      `CHK("damp", damp[2:0], o_aux_damping_code)
      rd(a, a == ACQ_BW_ADDR ? acq : a == AUX_DAMP_ADDR ? damp : 0);
    end
    $display("test random done");
    complete_run;
  end
endmodule
`default_nettype wire
